/* hdl/rfs_top.sv */
/*
 * Receive frame status word: builds one status word per finished frame,
 * decides keep or discard, queues kept words and serves them over Avalon-MM.
 * Assumes the receive path gives one done pulse per frame with its attributes
 * stable in that cycle, and that the host pops a word once it is done with it.
 */
`timescale 1ns/10ps
module rfs_top #(
    parameter int unsigned DEPTH = rfs_pkg::QUEUE_DEPTH
) (
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_rst,
    input  wire rfs_pkg::rfs_avs_req_s        i_avs,
    output logic      [rfs_pkg::DATA_W-1:0]   o_avs_readdata,
    output logic                              o_avs_waitrequest,
    input  wire logic                         i_rx_done,
    input  wire rfs_pkg::rfs_frame_s          i_rx_frame,
    output logic                              o_frame_keep,
    output logic                              o_frame_drop,
    output logic      [11:0]                  o_store_len
);

    localparam int unsigned CNT_W = $clog2(DEPTH + 1);

    rfs_pkg::rfs_status_s new_word;
    rfs_pkg::rfs_status_s head_word;
    rfs_pkg::rfs_status_s shown_word;
    logic [15:0]          head_raw;
    logic                 q_empty;
    logic                 q_full;
    logic [CNT_W-1:0]     q_count;
    logic                 frame_bad;
    logic                 keep;
    logic                 push;
    logic                 pop;
    logic                 pass_bad_r;
    logic                 ack_r;
    logic                 req;
    logic                 rd_take;
    logic                 wr_take;
    logic [31:0]          rd_nxt;
    logic [31:0]          rd_r;
    logic                 keep_r;
    logic                 drop_r;
    logic [11:0]          len_r;

    // ----------------------------------------------------------------
    // Status word of the frame that just finished
    // ----------------------------------------------------------------
    always_comb
    begin
        new_word                          = '0;
        new_word.icmp_checksum_error      = i_rx_frame.icmp_err;
        new_word.ip_header_checksum_error = i_rx_frame.ip_err;
        new_word.tcp_checksum_error       = i_rx_frame.tcp_err;
        new_word.udp_checksum_error       = i_rx_frame.udp_err;
        new_word.broadcast_dest_flag      = &i_rx_frame.dest_addr;
        new_word.multicast_dest_flag      = i_rx_frame.dest_addr[40];
        new_word.unicast_dest_flag        = !i_rx_frame.dest_addr[40];
        new_word.rx_symbol_error_flag     = i_rx_frame.symbol_err;
        new_word.ethertype_frame_flag     = i_rx_frame.len_type > rfs_pkg::ETHERTYPE_MIN_LEN;
        new_word.overlength_flag          = i_rx_frame.byte_count > rfs_pkg::MAX_FRAME_BYTES;
        new_word.runt_flag                = i_rx_frame.collision
                                          || (i_rx_frame.byte_count < rfs_pkg::MIN_FRAME_BYTES);
        new_word.fcs_error_flag           = i_rx_frame.crc_err;
    end

    // ----------------------------------------------------------------
    // Keep or discard decision
    // ----------------------------------------------------------------
    assign frame_bad = new_word.overlength_flag || new_word.runt_flag || new_word.fcs_error_flag;
    assign keep      = !frame_bad || pass_bad_r;
    assign push      = i_rx_done && keep && !q_full;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            keep_r <= 1'b0;
            drop_r <= 1'b0;
            len_r  <= '0;
        end
        else
        begin
            keep_r <= push;
            drop_r <= i_rx_done && !push;
            if (push)
                len_r <= i_rx_frame.byte_count;
        end
    end

    assign o_frame_keep = keep_r;
    assign o_frame_drop = drop_r;
    assign o_store_len  = len_r;

    // ----------------------------------------------------------------
    // Queue of pending status words
    // ----------------------------------------------------------------
    rfs_status_fifo #(
        .WIDTH (16),
        .DEPTH (DEPTH),
        .CNT_W (CNT_W)
    ) u_queue (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_push    (push),
        .i_data    (new_word),
        .i_pop     (pop),
        .o_head    (head_raw),
        .o_empty   (q_empty),
        .o_full    (q_full),
        .o_count   (q_count)
    );

    always_comb
    begin
        head_word                  = head_raw;
        shown_word                 = head_word;
        shown_word.frame_valid_flag = !q_empty;
        shown_word.rsvd14          = 1'b0;
        shown_word.rsvd9_8         = 2'h0;
        if (q_empty)
            shown_word = '0;
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave, one wait cycle on every access
    // ----------------------------------------------------------------
    assign req               = (i_avs.read || i_avs.write) && !ack_r;
    assign o_avs_waitrequest = (i_avs.read || i_avs.write) && !ack_r;
    assign rd_take           = i_avs.read && ack_r;
    assign wr_take           = i_avs.write && ack_r;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            ack_r <= 1'b0;
        else
            ack_r <= req;
    end

    always_comb
    begin
        rd_nxt = '0;
        if (i_avs.address == rfs_pkg::STATUS_OFS)
            rd_nxt = {16'h0000, shown_word};
        else if (i_avs.address == rfs_pkg::CTRL_OFS)
            rd_nxt[rfs_pkg::CTRL_PASS_BAD_BIT] = pass_bad_r;
        else if (i_avs.address == rfs_pkg::COUNT_OFS)
            rd_nxt = 32'(q_count);
        else
            rd_nxt = '0;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            rd_r <= '0;
        else if (req && i_avs.read)
            rd_r <= rd_nxt;
    end

    assign o_avs_readdata = rd_r;

    // ----------------------------------------------------------------
    // Control register and consume strobe
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            pass_bad_r <= rfs_pkg::CTRL_PASS_BAD_RST;
        else if (wr_take && (i_avs.address == rfs_pkg::CTRL_OFS) && i_avs.byteenable[0])
            pass_bad_r <= i_avs.writedata[rfs_pkg::CTRL_PASS_BAD_BIT];
    end

    // Writes to the status offset fall through with no effect
    assign pop = wr_take && (i_avs.address == rfs_pkg::RELEASE_OFS) && i_avs.byteenable[0]
              && i_avs.writedata[rfs_pkg::RELEASE_POP_BIT];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    valid_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && keep && q_empty ##1 !pop |-> shown_word.frame_valid_flag)
        else $error("frame valid flag missing after kept frame");

    empty_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (q_count == '0) |-> (shown_word == '0))
        else $error("status word not clear while nothing pending");

    checksum_bits_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        push |-> new_word[13:10] == {i_rx_frame.icmp_err, i_rx_frame.ip_err,
                                     i_rx_frame.tcp_err, i_rx_frame.udp_err})
        else $error("checksum error bits do not follow the frame");

    ip_into_head_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        push && q_empty && !pop ##1 1'b1 |-> shown_word.ip_header_checksum_error == $past(i_rx_frame.ip_err))
        else $error("ip checksum flag lost on the way to the head");

    addr_class_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        push |-> (new_word.broadcast_dest_flag == (i_rx_frame.dest_addr == 48'hffff_ffff_ffff))
              && (!new_word.broadcast_dest_flag || new_word.multicast_dest_flag))
        else $error("broadcast or multicast flag wrong");

    unicast_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        push |-> new_word.unicast_dest_flag != new_word.multicast_dest_flag)
        else $error("unicast flag not the inverse of multicast");

    frame_type_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        push && (i_rx_frame.len_type == 16'h05dd) |-> new_word.ethertype_frame_flag)
        else $error("frame type flag clear above 1500");

    overlength_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done |-> new_word.overlength_flag == (i_rx_frame.byte_count >= 12'h7d1))
        else $error("overlength flag wrong against 2000 bytes");

    bad_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && frame_bad && !pass_bad_r |=> o_frame_drop && !o_frame_keep)
        else $error("bad frame not discarded without pass-bad");

    full_length_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        push |=> o_frame_keep && (o_store_len == $past(i_rx_frame.byte_count)))
        else $error("stored length differs from received length");

    runt_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && i_rx_frame.collision |-> new_word.runt_flag)
        else $error("collision did not mark a runt");

    runt_pass_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && new_word.runt_flag && pass_bad_r && !q_full |=> o_frame_keep)
        else $error("runt not kept with pass-bad set");

    crc_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && i_rx_frame.crc_err && !pass_bad_r |=> $stable(q_count) || $past(pop))
        else $error("crc error frame was queued without pass-bad");

    reserved_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_take && (i_avs.address == rfs_pkg::STATUS_OFS)
        |-> (o_avs_readdata[14] == 1'b0) && (o_avs_readdata[9:8] == 2'h0) && (o_avs_readdata[31:16] == 16'h0000))
        else $error("reserved status bits not zero");

    consume_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pop && !q_empty && !push |=> q_count == $past(q_count) - CNT_W'(1))
        else $error("consume did not advance the queue");

    bus_answer_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(i_avs.read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("read not answered after one wait cycle");

    // ----------------------------------------------------------------
    // Frame path checks
    // ----------------------------------------------------------------
    one_answer_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done |=> o_frame_keep != o_frame_drop)
        else $error("frame not answered by exactly one of keep and drop");

    quiet_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_rx_done |=> !o_frame_keep && !o_frame_drop)
        else $error("keep or drop pulse without a finished frame");

    good_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && !frame_bad && !q_full |=> o_frame_keep)
        else $error("good frame not kept while room is left");

    full_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && q_full |=> o_frame_drop)
        else $error("frame not dropped while the queue is full");

    long_pass_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && new_word.overlength_flag && pass_bad_r && !q_full |=> o_frame_keep)
        else $error("over-length frame not kept with pass-bad set");

    crc_pass_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && i_rx_frame.crc_err && pass_bad_r && !q_full |=> o_frame_keep)
        else $error("crc error frame not kept with pass-bad set");

    symbol_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        push |-> new_word.rx_symbol_error_flag == i_rx_frame.symbol_err)
        else $error("symbol error flag does not follow the frame");

    type_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        push && (i_rx_frame.len_type == 16'h05dc) |-> !new_word.ethertype_frame_flag)
        else $error("frame type flag set at 1500");

    runt_short_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && (i_rx_frame.byte_count == 12'h03f) |-> new_word.runt_flag)
        else $error("short frame not marked as runt");

    runt_edge_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_rx_done && !i_rx_frame.collision && (i_rx_frame.byte_count == 12'h040) |-> !new_word.runt_flag)
        else $error("minimum length frame marked as runt");

    crc_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        push |-> new_word.fcs_error_flag == i_rx_frame.crc_err)
        else $error("crc error flag does not follow the frame");

    count_push_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        push && !pop |=> q_count == $past(q_count) + CNT_W'(1))
        else $error("kept frame not counted");

    head_valid_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !q_empty |-> shown_word.frame_valid_flag)
        else $error("frame valid flag clear while a frame is pending");

    // ----------------------------------------------------------------
    // Bus checks
    // ----------------------------------------------------------------
    write_answer_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(i_avs.write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("write not answered after one wait cycle");

    ctrl_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_take && (i_avs.address == rfs_pkg::CTRL_OFS) |-> o_avs_readdata == {31'h0, pass_bad_r})
        else $error("control read does not show pass-bad");

    ctrl_only_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_take && (i_avs.address != rfs_pkg::CTRL_OFS) |=> $stable(pass_bad_r))
        else $error("pass-bad changed by a write elsewhere");

endmodule

/* hdl/rfs_pkg.sv */
/*
 * Constants and carrier types of the receive frame status word block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package rfs_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS    = 8'h70;
    localparam logic [7:0] COUNT_OFS   = 8'h74;
    localparam logic [7:0] RELEASE_OFS = 8'h78;
    localparam logic [7:0] STATUS_OFS  = 8'h7c;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_PASS_BAD_BIT = 0;
    localparam int unsigned RELEASE_POP_BIT   = 0;
    localparam logic        CTRL_PASS_BAD_RST = 1'b0;
    localparam int unsigned QUEUE_DEPTH       = 8;

    // ----------------------------------------------------------------
    // Frame length limits in bytes
    // ----------------------------------------------------------------
    localparam logic [15:0] ETHERTYPE_MIN_LEN = 16'h05dc;
    localparam logic [11:0] MAX_FRAME_BYTES   = 12'h7d0;
    localparam logic [11:0] MIN_FRAME_BYTES   = 12'h040;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              frame_valid_flag;
        logic              rsvd14;
        logic              icmp_checksum_error;
        logic              ip_header_checksum_error;
        logic              tcp_checksum_error;
        logic              udp_checksum_error;
        logic [1:0]        rsvd9_8;
        logic              broadcast_dest_flag;
        logic              multicast_dest_flag;
        logic              unicast_dest_flag;
        logic              rx_symbol_error_flag;
        logic              ethertype_frame_flag;
        logic              overlength_flag;
        logic              runt_flag;
        logic              fcs_error_flag;
    } rfs_status_s;

    typedef struct packed {
        logic [47:0]       dest_addr;
        logic [15:0]       len_type;
        logic [11:0]       byte_count;
        logic              icmp_err;
        logic              ip_err;
        logic              tcp_err;
        logic              udp_err;
        logic              symbol_err;
        logic              collision;
        logic              crc_err;
    } rfs_frame_s;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [DATA_W-1:0] writedata;
        logic [3:0]        byteenable;
    } rfs_avs_req_s;

endpackage

/* hdl/rfs_status_fifo.sv */
/*
 * Flip-flop queue of frame status words, head shown on the output.
 * Assumes push is only requested while not full.
 */
`timescale 1ns/10ps
module rfs_status_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned CNT_W = $clog2(DEPTH + 1)
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic             i_push,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_pop,
    output logic      [WIDTH-1:0] o_head,
    output logic                  o_empty,
    output logic                  o_full,
    output logic      [CNT_W-1:0] o_count
);

    localparam int unsigned IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [IDX_W-1:0] wr_idx_r;
    logic [IDX_W-1:0] rd_idx_r;
    logic [CNT_W-1:0] count_r;
    logic             do_push;
    logic             do_pop;

    assign do_push = i_push && (count_r != CNT_W'(DEPTH));
    assign do_pop  = i_pop && (count_r != '0);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    for (genvar e = 0; e < DEPTH; e++)
    begin : g_entry
        always_ff @(posedge i_clk_sys or posedge i_rst)
        begin
            if (i_rst)
                mem_r[e] <= '0;
            else if (do_push && (wr_idx_r == IDX_W'(e)))
                mem_r[e] <= i_data;
        end
    end

    // ----------------------------------------------------------------
    // Pointers and fill count
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (do_push)
                wr_idx_r <= (wr_idx_r == IDX_W'(DEPTH - 1)) ? '0 : wr_idx_r + IDX_W'(1);
            if (do_pop)
                rd_idx_r <= (rd_idx_r == IDX_W'(DEPTH - 1)) ? '0 : rd_idx_r + IDX_W'(1);
            if (do_push && !do_pop)
                count_r <= count_r + CNT_W'(1);
            else if (do_pop && !do_push)
                count_r <= count_r - CNT_W'(1);
        end
    end

    assign o_head  = mem_r[rd_idx_r];
    assign o_empty = (count_r == '0);
    assign o_full  = (count_r == CNT_W'(DEPTH));
    assign o_count = count_r;

endmodule

/* test/rfs_host_model.sv */
/*
 * Host model: Avalon-MM master that reads and writes the block's registers.
 * Assumes one clock, and a slave that lowers waitrequest to finish each access.
 */
`timescale 1ns/10ps
module rfs_host_model (
    input  wire logic                       i_clk_sys,
    input  wire logic [rfs_pkg::DATA_W-1:0] i_readdata,
    input  wire logic                       i_waitrequest,
    output rfs_pkg::rfs_avs_req_s           o_avs,
    output logic                            o_timeout
);
    initial
    begin
        o_avs     = '0;
        o_timeout = 1'b0;
    end

    // One access: request held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        o_avs.address    <= adr;
        o_avs.read       <= ~wr;
        o_avs.write      <= wr;
        o_avs.writedata  <= wd;
        o_avs.byteenable <= 4'hf;
        do
        begin
            @(posedge i_clk_sys);
            n++;
        end
        while (i_waitrequest !== 1'b0 && n < 50);
        rd = i_readdata;
        if (n >= 50)
            o_timeout = 1'b1;
        o_avs.read  <= 1'b0;
        o_avs.write <= 1'b0;
    endtask
endmodule

/* test/test_rfs_top.sv */
/*
 * Bench for the receive frame status word: frames in, status words read back.
 * Assumes the host model drives the register bus and DEPTH is shortened to 4.
 */
`timescale 1ns/10ps
module test_rfs_top;
    localparam int unsigned DEPTH = 4;
    logic                       i_clk_sys = 1'b0;
    logic                       i_rst = 1'b1;
    rfs_pkg::rfs_avs_req_s      avs;
    logic [rfs_pkg::DATA_W-1:0] rdata;
    logic                       wait_req;
    logic                       timeout;
    logic                       rx_done = 1'b0;
    rfs_pkg::rfs_frame_s        frame = '0;
    logic                       keep;
    logic                       drop;
    logic [11:0]                store_len;
    rfs_pkg::rfs_frame_s        tbl [7];
    logic [31:0]                kept [$];
    logic [31:0]                q;
    int                         n_errors = 0;
    int                         n_tests = 0;

    always #50 i_clk_sys = ~i_clk_sys;

    rfs_top #(.DEPTH(DEPTH)) DUT (
        .i_clk_sys         (i_clk_sys),
        .i_rst             (i_rst),
        .i_avs             (avs),
        .o_avs_readdata    (rdata),
        .o_avs_waitrequest (wait_req),
        .i_rx_done         (rx_done),
        .i_rx_frame        (frame),
        .o_frame_keep      (keep),
        .o_frame_drop      (drop),
        .o_store_len       (store_len)
    );

    rfs_host_model host (
        .i_clk_sys     (i_clk_sys),
        .i_readdata    (rdata),
        .i_waitrequest (wait_req),
        .o_avs         (avs),
        .o_timeout     (timeout)
    );

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        host.xfer(wr, adr, wd, q);
        if (timeout === 1'b1)
        begin
            n_errors++;
            $display("wrong value at %0t: bus access timed out", $time);
            test_done();
        end
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        check(q, exp, "register read");
    endtask

    function automatic rfs_pkg::rfs_frame_s mk(input logic [47:0] d, input logic [15:0] lt,
                                               input logic [11:0] bc, input logic [6:0] e);
        return rfs_pkg::rfs_frame_s'({d, lt, bc, e});
    endfunction

    // Upper half: compare mask, lower half: expected status word
    function automatic logic [31:0] exp_word(input rfs_pkg::rfs_frame_s f);
        logic runt;
        runt = f.collision | (f.byte_count < 12'h040);
        return {12'hfff, ~runt, 3'h7,
                2'b10, f.icmp_err, f.ip_err, f.tcp_err, f.udp_err, 2'b00,
                &f.dest_addr, f.dest_addr[40], ~f.dest_addr[40],
                f.symbol_err, f.len_type > 16'h05dc,
                f.byte_count > 12'h7d0, runt, f.crc_err};
    endfunction

    task automatic send(input rfs_pkg::rfs_frame_s f, input logic exp_keep);
        @(posedge i_clk_sys);
        rx_done <= 1'b1;
        frame   <= f;
        @(posedge i_clk_sys);
        rx_done <= 1'b0;
        #1;
        check({30'h0, keep, drop}, {30'h0, exp_keep, ~exp_keep}, "keep or drop");
        if (exp_keep)
        begin
            check({20'h0, store_len}, {20'h0, f.byte_count}, "stored length");
            kept.push_back(exp_word(f));
        end
    endtask

    task automatic drain();
        logic [31:0] e;
        rd_chk(rfs_pkg::COUNT_OFS, 32'(kept.size()));
        while (kept.size() > 0)
        begin
            e = kept.pop_front();
            bus(1'b0, rfs_pkg::STATUS_OFS, 32'h0);
            check(q & {16'hffff, e[31:16]}, {16'h0, e[15:0] & e[31:16]}, "status word");
            bus(1'b1, rfs_pkg::RELEASE_OFS, 32'h1);
        end
        rd_chk(rfs_pkg::COUNT_OFS, 32'h0);
        rd_chk(rfs_pkg::STATUS_OFS, 32'h0);
    endtask

    initial
    begin
        tbl[0] = mk(48'hffff_ffff_ffff, 16'h0800, 12'h064, 7'h00);
        tbl[1] = mk(48'h0200_0000_0001, 16'h05dc, 12'h040, 7'h60);
        tbl[2] = mk(48'h0100_5e00_0001, 16'h05dd, 12'h7d0, 7'h1c);
        tbl[3] = mk(48'h0200_0000_0002, 16'h0800, 12'h7d1, 7'h00);
        tbl[4] = mk(48'h0200_0000_0003, 16'h0600, 12'h03f, 7'h00);
        tbl[5] = mk(48'h0300_0000_0004, 16'h0800, 12'h064, 7'h02);
        tbl[6] = mk(48'h0200_0000_0005, 16'h0800, 12'h064, 7'h01);
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd_chk(rfs_pkg::CTRL_OFS, 32'h0);
        rd_chk(8'h40, 32'h0);
        rd_chk(rfs_pkg::RELEASE_OFS, 32'h0);
        bus(1'b1, rfs_pkg::STATUS_OFS, 32'hffff_ffff);
        drain();
        for (int i = 0; i < 7; i++)
            send(tbl[i], i < 3);
        drain();
        bus(1'b1, rfs_pkg::CTRL_OFS, 32'h1);
        rd_chk(rfs_pkg::CTRL_OFS, 32'h1);
        for (int i = 3; i < 7; i++)
            send(tbl[i], 1'b1);
        send(tbl[0], 1'b0);
        drain();
        test_done();
    end
endmodule
